/* File: rtl/period_timer_pkg.sv */
/*
  Shared constants and types for the 8-bit period match timer: register
  indices and byte addresses, reset values, field layouts and divider limits.
  Assumes a 32-bit APB master and one system clock.
*/
package period_timer_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_CONTROL = 16'h0FCA;
  localparam logic [15:0] IDX_COUNT   = 16'h0FCB;
  localparam logic [15:0] IDX_PERIOD  = 16'h0FCC;
  localparam logic [15:0] IDX_FLAGS   = 16'h0FCD;
  localparam logic [15:0] IDX_ENABLES = 16'h0FCE;

  // Values after reset.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] PERIOD_RESET  = 8'hFF;
  localparam logic [7:0] FLAGS_RESET   = 8'h00;

  // Position of the match flag and its enable in their registers.
  localparam int unsigned MATCH_BIT = 1;

  // System clocks per instruction clock, less one.
  localparam logic [1:0] INSTR_LAST = 2'h3;

  // Last prescaler state for each divide ratio.
  localparam logic [3:0] PRE_LAST_DIV1  = 4'h0;
  localparam logic [3:0] PRE_LAST_DIV4  = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic       unused;
    logic [3:0] matchDivideSelect;
    logic       countRun;
    logic [1:0] inputDivideSelect;
  } timer_control_t;

  // APB request group driven by the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // Byte address of a register index.
  function automatic logic [15:0] regByteAddr(input logic [15:0] idx);
    regByteAddr = {idx[13:0], 2'b00};
  endfunction

  // Last prescaler state for a divide select code.
  function automatic logic [3:0] preLast(input logic [1:0] sel);
    preLast = sel[1] ? PRE_LAST_DIV16 : (sel[0] ? PRE_LAST_DIV4 : PRE_LAST_DIV1);
  endfunction

endpackage

/* File: rtl/input_prescaler.sv */
/*
  Instruction clock divider and input prescaler. Produces one-cycle count
  ticks. Assumes clear is a one-cycle pulse from the register logic.
*/
`timescale 1ns/1ps

module input_prescaler
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       run,
  input  wire logic [1:0] select,
  output logic            tick
);

  import period_timer_pkg::*;

  logic [1:0] phase_r;
  logic [3:0] pre_r;
  logic       instrTick;
  logic       preWrap;

  ////////////////////////////////////////////////////////////////////////
  // Both counters hold while stopped, so a stopped timer does not toggle.
  assign instrTick = run && (phase_r == INSTR_LAST);
  assign preWrap   = pre_r == preLast(select);
  assign tick      = instrTick && preWrap && !clear;

  // Phase of the instruction clock, cleared along with the prescaler.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      phase_r <= 2'h0;
    else if (clear)
      phase_r <= 2'h0;
    else if (run)
      phase_r <= phase_r + 2'h1;
  end

  // Prescaler; a select change mid-count wraps at the new limit at once.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pre_r <= 4'h0;
    else if (clear)
      pre_r <= 4'h0;
    else if (instrTick)
      pre_r <= (pre_r >= preLast(select)) ? 4'h0 : pre_r + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_TICK_GAP: assert property (tick |=> (!tick) [*3])
    else $error("Count ticks closer than one instruction cycle.");
  // Software may switch to divide-by-1 right after a tick, so only ticks that
  // still see the divide-by-4 select count against the gap.
  AST_DIV4_GAP: assert property (
    tick && select == 2'h1 |=> (!tick || select != 2'h1) [*8])
    else $error("Divide-by-4 tick came too early.");

endmodule

/* File: rtl/period_match_timer_8bit.sv */
/*
  8-bit period match timer with prescaler, postscaler, match flag and
  interrupt, reached over APB. Assumes a 32-bit APB master, zero-skew
  single clock at the system oscillator rate, and an asynchronous reset
  that stands for every kind of device reset.
*/
// Local design decision: register access over APB.
// Overview of operation
// - While running, the count rises by one from zero on each prescaled instruction tick.
// - The input divide select picks 1, 4 or 16 instruction cycles per tick.
// - The count is compared with the period every cycle and equality gives the match.
// - A match clears the count on the next tick and clocks the postscaler.
// - Reset clears the count and loads the period with all ones.
// - Writes to count or control and any reset clear prescaler and postscaler.
// - A control write leaves the count untouched.
// - The match divide select n in control bits 6 to 3 divides matches by n plus one.
// - The match flag, flags bit 1, sets each time the postscaler completes.
// - The interrupt is raised from the flag only while its enable bit is set.
// - The unscaled match pulse is output as a PWM time base.
// - The match also drives a shift clock output for a serial port.
// - Count and period are read and written directly, unbuffered.
`timescale 1ns/1ps

module period_match_timer_8bit
(
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire period_timer_pkg::apb_req_t apbReq,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           irq,
  output logic                           pwmTimeBase,
  output logic                           serialShiftClock
);

  import period_timer_pkg::*;

  timer_control_t control_r;
  logic [7:0]     count_r;
  logic [7:0]     count_nxt;
  logic [7:0]     period_r;
  logic [3:0]     post_r;
  logic [3:0]     post_nxt;
  logic           flag_r;
  logic           flag_nxt;
  logic           enable_r;
  logic           enable_nxt;
  logic           pready_r;
  logic           pslverr_r;
  logic [31:0]    prdata_r;
  logic           irq_r;
  logic           timeBase_r;
  logic           shiftClock_r;

  logic           accessDone;
  logic           writeDone;
  logic           hitControl;
  logic           hitCount;
  logic           hitPeriod;
  logic           hitFlags;
  logic           hitEnables;
  logic           hitAny;
  logic           wrControl;
  logic           wrCount;
  logic           wrPeriod;
  logic           wrFlags;
  logic           wrEnables;
  logic           flagClear;
  logic [31:0]    readData;
  logic           prescClear;
  logic           tick;
  logic           atPeriod;
  logic           matchPulse;
  logic           postWrap;
  logic           postDone;

  ////////////////////////////////////////////////////////////////////////
  // Address decode. Only full matches hit; everything else is unmapped.
  assign hitControl = apbReq.paddr == regByteAddr(IDX_CONTROL);
  assign hitCount   = apbReq.paddr == regByteAddr(IDX_COUNT);
  assign hitPeriod  = apbReq.paddr == regByteAddr(IDX_PERIOD);
  assign hitFlags   = apbReq.paddr == regByteAddr(IDX_FLAGS);
  assign hitEnables = apbReq.paddr == regByteAddr(IDX_ENABLES);
  assign hitAny     = hitControl || hitCount || hitPeriod || hitFlags || hitEnables;

  // A transfer completes at the edge where the registered ready is high.
  assign accessDone = apbReq.psel && apbReq.penable && pready_r;
  assign writeDone  = accessDone && apbReq.pwrite;
  assign wrControl  = writeDone && hitControl;
  assign wrCount    = writeDone && hitCount;
  assign wrPeriod   = writeDone && hitPeriod;
  assign wrFlags    = writeDone && hitFlags;
  assign wrEnables  = writeDone && hitEnables;
  assign flagClear  = wrFlags && apbReq.pwdata[MATCH_BIT];

  // Read selection; narrow registers sit in the low bits, the rest read zero.
  assign readData =
    hitControl ? {24'h000000, 1'b0, control_r[6:0]} :
    hitCount   ? {24'h000000, count_r} :
    hitPeriod  ? {24'h000000, period_r} :
    hitFlags   ? {30'h00000000, flag_r, 1'b0} :
    hitEnables ? {30'h00000000, enable_r, 1'b0} :
    32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // One wait state: ready rises after the first access cycle, so every
  // transfer takes exactly setup plus two access cycles. The registered
  // answer keeps the bus outputs glitch free at the cost of that cycle.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end
    else
    begin
      pready_r  <= apbReq.psel && apbReq.penable && !pready_r;
      pslverr_r <= apbReq.psel && apbReq.penable && !pready_r && !hitAny;
      if (apbReq.psel && apbReq.penable && !pready_r)
        prdata_r <= apbReq.pwrite ? 32'h00000000 : readData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and period registers. Reserved bit 7 is never stored.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      control_r <= CONTROL_RESET;
      period_r  <= PERIOD_RESET;
    end
    else
    begin
      if (wrControl)
        control_r <= {1'b0, apbReq.pwdata[6:0]};
      if (wrPeriod)
        period_r <= apbReq.pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler, cleared by writes to count or control; reset clears it too.
  assign prescClear = wrCount || wrControl;

  input_prescaler prescaler_u (
    .clock  (clock),
    .rst    (rst),
    .clear  (prescClear),
    .run    (control_r.countRun),
    .select (control_r.inputDivideSelect),
    .tick   (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Comparator and count. The match is a combinational compare every cycle;
  // the count wraps to zero on the tick that finds it equal, so the period
  // is period plus one ticks. A software write beats a tick in that cycle.
  assign atPeriod   = count_r == period_r;
  assign matchPulse = tick && atPeriod && !wrCount;
  assign count_nxt  = wrCount    ? apbReq.pwdata[7:0] :
                      matchPulse ? COUNT_RESET :
                      tick       ? count_r + 8'h01 :
                      count_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      count_r <= COUNT_RESET;
    else
      count_r <= count_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Postscaler counts matches; a select below the current state wraps at
  // once so a shortened ratio never runs the full sixteen.
  assign postWrap = post_r >= control_r.matchDivideSelect;
  assign postDone = matchPulse && postWrap && !prescClear;
  assign post_nxt = prescClear ? 4'h0 :
                    !matchPulse ? post_r :
                    postWrap ? 4'h0 : post_r + 4'h1;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      post_r <= 4'h0;
    else
      post_r <= post_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky flag, cleared by writing one; a new event beats the clear.
  assign flag_nxt   = postDone || (flag_r && !flagClear);
  assign enable_nxt = wrEnables ? apbReq.pwdata[MATCH_BIT] : enable_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      flag_r   <= FLAGS_RESET[MATCH_BIT];
      enable_r <= FLAGS_RESET[MATCH_BIT];
      irq_r    <= 1'b0;
    end
    else
    begin
      flag_r   <= flag_nxt;
      enable_r <= enable_nxt;
      irq_r    <= flag_nxt && enable_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Match outputs. The time base is a one-cycle pulse per match; the shift
  // clock toggles per match, so its rate is half the match rate and its
  // duty cycle is even whatever the period.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      timeBase_r   <= 1'b0;
      shiftClock_r <= 1'b0;
    end
    else
    begin
      timeBase_r <= matchPulse;
      if (matchPulse)
        shiftClock_r <= !shiftClock_r;
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign irq              = irq_r;
  assign pwmTimeBase      = timeBase_r;
  assign serialShiftClock = shiftClock_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the counting, scaling and flag behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_COUNT_STEP: assert property (
    tick && !atPeriod && !wrCount |=> count_r == $past(count_r) + 8'h01)
    else $error("Count did not step by one on a tick.");

  AST_PERIOD_WRAP: assert property (
    tick && atPeriod && !wrCount |=> count_r == 8'h00 && timeBase_r)
    else $error("Count did not wrap to zero after a match.");

  AST_HOLD_STOPPED: assert property (
    !control_r.countRun && !wrCount |=> count_r == $past(count_r))
    else $error("Count moved while stopped.");

  AST_CTRL_KEEPS_COUNT: assert property (
    wrControl |=> count_r == $past(count_r) && post_r == 4'h0)
    else $error("Control write disturbed count or left postscaler set.");

  AST_COUNT_WRITE: assert property (
    wrCount |=> count_r == $past(apbReq.pwdata[7:0]) && post_r == 4'h0)
    else $error("Count write not taken directly.");

  AST_RESET_VALUES: assert property (disable iff (1'b0)
    $fell(rst) |-> count_r == 8'h00 && period_r == 8'hFF && post_r == 4'h0)
    else $error("Wrong count or period after reset.");

  AST_FLAG_SET: assert property (
    postDone |=> flag_r ##0 (irq_r == enable_r))
    else $error("Postscaler completion did not set the flag.");

  AST_FLAG_STICKY: assert property (
    flag_r && !flagClear |=> flag_r)
    else $error("Match flag cleared without software.");

  AST_IRQ_GATE: assert property (
    !enable_r || !flag_r |-> !irq_r)
    else $error("Interrupt raised while masked or idle.");

  AST_SHIFT_TOGGLE: assert property (
    matchPulse |=> serialShiftClock != $past(serialShiftClock))
    else $error("Shift clock did not toggle on a match.");

  AST_POST_RATIO: assert property (
    matchPulse && control_r.matchDivideSelect == 4'h0 && !prescClear |=> flag_r)
    else $error("1:1 postscale did not flag every match.");

  AST_POST_STEP: assert property (
    matchPulse && !postWrap |=> post_r == $past(post_r) + 4'h1)
    else $error("Postscaler did not step by one on a match.");

  AST_POST_HOLD: assert property (
    !matchPulse && !prescClear |=> post_r == $past(post_r))
    else $error("Postscaler moved without a match.");

  AST_PRESC_CLEARED: assert property (
    prescClear |=> (!tick) [*3])
    else $error("Tick came too soon after a prescaler clear.");

  AST_STOPPED_NO_TICK: assert property (
    !control_r.countRun |-> !tick)
    else $error("Tick seen while the timer is stopped.");

  AST_FLAG_CLEAR: assert property (
    flagClear && !postDone |=> !flag_r)
    else $error("Writing one did not clear the match flag.");

  AST_FLAG_SOURCE: assert property (
    !flag_r && !postDone |=> !flag_r)
    else $error("Match flag set without postscaler completion.");

  AST_BASE_ONLY_MATCH: assert property (
    !matchPulse |=> !timeBase_r)
    else $error("Time base pulsed without a match.");

  AST_SHIFT_HOLD: assert property (
    !matchPulse |=> serialShiftClock == $past(serialShiftClock))
    else $error("Shift clock moved without a match.");

  AST_PERIOD_WRITE: assert property (
    wrPeriod |=> period_r == $past(apbReq.pwdata[7:0]))
    else $error("Period write not taken directly.");

  AST_PERIOD_HOLD: assert property (
    !wrPeriod |=> period_r == $past(period_r))
    else $error("Period changed without a write.");

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake checks; software reaches every register through these.

  AST_READY_PULSE: assert property (
    pready_r |=> !pready_r)
    else $error("Ready stood for more than one cycle.");

  AST_READY_WAIT: assert property (
    apbReq.psel && apbReq.penable && !pready_r |=> pready_r)
    else $error("Ready did not follow the first access cycle.");

  AST_ERR_WITH_READY: assert property (
    pslverr_r |-> pready_r)
    else $error("Error response without ready.");

endmodule

/* File: verif/period_match_timer_8bit_bench.sv */
/*
  Self-checking bench for the 8-bit period match timer: drives the APB port
  and the reset, and judges the register, timer, flag and interrupt outputs.
  Assumes the register indices and reset values of period_timer_pkg.
*/
`timescale 1ns/1ps

module period_match_timer_8bit_bench;
  import period_timer_pkg::*;

  logic        clock;
  logic        rst;
  apb_req_t    apbReq;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        pwmTimeBase;
  logic        serialShiftClock;
  logic [31:0] rdv;
  logic        errv;
  int          bad_count;
  int          tests_run;

  period_match_timer_8bit DUT (
    .clock            (clock),
    .rst              (rst),
    .apbReq           (apbReq),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .irq              (irq),
    .pwmTimeBase      (pwmTimeBase),
    .serialShiftClock (serialShiftClock)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and the watchdog that cuts a hang short.
  initial clock = 1'b0;
  always #4 clock = ~clock;

  initial
  begin
    #400000;
    bad_count++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared comparison and bus tasks.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is seen at an edge.
  // The wait has no bound of its own: only the watchdog ends a hang.
  task automatic apbXfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge clock);
    apbReq.psel    <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite  <= wr;
    apbReq.paddr   <= {idx[13:0], 2'b00};
    apbReq.pwdata  <= wd;
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic rdChk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    apbXfer(1'b0, idx, 32'h0000_0000);
    check(what, rdv, exp);
  endtask

  // Counts edges until the next match pulse, bounded.
  task automatic waitPulse(output int t);
    t = 0;
    do
    begin
      @(posedge clock);
      t++;
    end
    while (pwmTimeBase !== 1'b1 && t < 3000);
    check("pulse wait", {31'h0, pwmTimeBase}, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic testReset();
    rdChk("control", IDX_CONTROL, 32'h0000_0000);
    rdChk("count", IDX_COUNT, 32'h0000_0000);
    rdChk("period", IDX_PERIOD, 32'h0000_00FF);
    rdChk("flags", IDX_FLAGS, 32'h0000_0000);
    check("irq idle", {31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask

  // Direct access, the read-only top control bit and an unmapped place.
  task automatic testRegs();
    apbXfer(1'b1, IDX_PERIOD, 32'h0000_005A);
    rdChk("period rw", IDX_PERIOD, 32'h0000_005A);
    apbXfer(1'b1, IDX_COUNT, 32'h0000_0012);
    rdChk("count rw", IDX_COUNT, 32'h0000_0012);
    apbXfer(1'b1, IDX_CONTROL, 32'h0000_00FB);
    rdChk("control bit7", IDX_CONTROL, 32'h0000_007B);
    apbXfer(1'b1, IDX_CONTROL, 32'h0000_0000);
    rdChk("count kept", IDX_COUNT, 32'h0000_0012);
    rdChk("count stopped", IDX_COUNT, 32'h0000_0012);
    apbXfer(1'b0, 16'h0100, 32'h0000_0000);
    check("unmapped err", {31'h0, errv}, 32'h1);
    check("unmapped data", rdv, 32'h0);
    $display("test regs done");
  endtask

  // Match period for every prescaler code, and the shift clock toggle.
  task automatic testPeriod();
    int t;
    int ratio;
    logic sc;
    apbXfer(1'b1, IDX_PERIOD, 32'h0000_0003);
    for (int sel = 0; sel < 4; sel++)
    begin
      ratio = (sel == 0) ? 1 : ((sel == 1) ? 4 : 16);
      apbXfer(1'b1, IDX_COUNT, 32'h0000_0000);
      apbXfer(1'b1, IDX_CONTROL, 32'h4 | sel);
      waitPulse(t);
      sc = serialShiftClock;
      waitPulse(t);
      check("match spacing", t, 4 * 4 * ratio);
      check("shift clock", {31'h0, serialShiftClock}, {31'h0, ~sc});
    end
    $display("test period done");
  endtask

  // Postscaler ratios, sticky flag, write-one clear and the enable mask.
  task automatic testFlag();
    int n;
    int seen;
    logic [3:0] codes [3] = '{4'h0, 4'h2, 4'hF};
    apbXfer(1'b1, IDX_PERIOD, 32'h0000_0000);
    apbXfer(1'b1, IDX_ENABLES, 32'h0000_0002);
    foreach (codes[i])
    begin
      apbXfer(1'b1, IDX_CONTROL, 32'h0000_0000);
      apbXfer(1'b1, IDX_FLAGS, 32'h0000_0002);
      // The interrupt is registered, so look one edge after the write lands.
      @(posedge clock);
      check("irq cleared", {31'h0, irq}, 32'h0);
      apbXfer(1'b1, IDX_CONTROL, {25'h0, codes[i], 3'h4});
      seen = 0;
      n = 0;
      while (irq !== 1'b1 && n < 2000)
      begin
        @(posedge clock);
        n++;
        if (pwmTimeBase === 1'b1)
          seen++;
      end
      check("irq raised", {31'h0, irq}, 32'h1);
      @(posedge clock);
      if (pwmTimeBase === 1'b1)
        seen++;
      check("matches per flag", seen, codes[i] + 1);
    end
    apbXfer(1'b1, IDX_CONTROL, 32'h0000_0000);
    rdChk("flag sticky", IDX_FLAGS, 32'h0000_0002);
    apbXfer(1'b1, IDX_ENABLES, 32'h0000_0000);
    @(posedge clock);
    check("irq masked", {31'h0, irq}, 32'h0);
    apbXfer(1'b1, IDX_ENABLES, 32'h0000_0002);
    @(posedge clock);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    apbXfer(1'b1, IDX_FLAGS, 32'h0000_0002);
    rdChk("flag cleared", IDX_FLAGS, 32'h0000_0000);
    $display("test flag done");
  endtask

  // A reset in mid-run, with the count away from zero, restores the registers.
  task automatic testMidReset();
    apbXfer(1'b1, IDX_PERIOD, 32'h0000_0033);
    apbXfer(1'b1, IDX_CONTROL, 32'h0000_0004);
    repeat (40) @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rdChk("count mid reset", IDX_COUNT, 32'h0000_0000);
    rdChk("period mid reset", IDX_PERIOD, 32'h0000_00FF);
    rdChk("control mid reset", IDX_CONTROL, 32'h0000_0000);
    rdChk("count held after reset", IDX_COUNT, 32'h0000_0000);
    $display("test mid reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    apbReq = '0;
    bad_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    testReset();
    testRegs();
    testPeriod();
    testFlag();
    testMidReset();
    print_verdict();
  end

endmodule
